// ---- cmp_pkg.sv ----
// Purpose: Constants for the mailbox transmit-pending and unread-status block.
// Assumes: An 8-bit CPU register bus and four mailboxes, mailbox 0 receive-only.
// Notes:   Offsets are byte addresses on the CPU bus.
//
// Contract
// - Writing 1 to a pending bit queues mailboxes 3 to 1 for arbitration.
// - Writing 0 to a pending bit changes nothing.
// - A pending bit sets only while its direction bit is 0.
// - Successful send clears pending and sets transmit acknowledge together.
// - Finished cancel of an unsent message clears pending, sets abort acknowledge.
// - Cancel during send then error or lost arbitration clears pending, sets abort.
// - With retransmission disabled, error or lost arbitration clears pending.
// - Otherwise a failed attempt keeps pending set and is retried.
// - Any pending bit clearing sets the empty-mailbox flag in interrupt flags 1.
// - Receive-direction mailboxes never transmit; cancel request clears their pending.
// - Pending bits 7 to 4 and bit 0 read 0; bit 0 is unwritable.
// - New message before receive or remote flag cleared sets unread status.
// - Unread status clears only by writing 1; bits 7 to 4 read 0.
// - Registers are 8 bits wide and each access takes 4 clock states.
package cmp_pkg;

  localparam logic [15:0] CMP_OFS_MASTER_CONTROL = 16'hF600;
  localparam logic [15:0] CMP_OFS_GENERAL_STATUS = 16'hF601;
  localparam logic [15:0] CMP_OFS_BIT_TIMING_1   = 16'hF602;
  localparam logic [15:0] CMP_OFS_BIT_TIMING_0   = 16'hF603;
  localparam logic [15:0] CMP_OFS_DIRECTION      = 16'hF604;
  localparam logic [15:0] CMP_OFS_MODULE_CONTROL = 16'hF605;
  localparam logic [15:0] CMP_OFS_PENDING        = 16'hF606;
  localparam logic [15:0] CMP_OFS_CANCEL         = 16'hF608;
  localparam logic [15:0] CMP_OFS_TX_ACK         = 16'hF60A;
  localparam logic [15:0] CMP_OFS_ABORT_ACK      = 16'hF60C;
  localparam logic [15:0] CMP_OFS_RX_COMPLETE    = 16'hF60E;
  localparam logic [15:0] CMP_OFS_REMOTE_REQ     = 16'hF610;
  localparam logic [15:0] CMP_OFS_IRQ_FLAGS_1    = 16'hF612;
  localparam logic [15:0] CMP_OFS_IRQ_FLAGS_0    = 16'hF613;
  localparam logic [15:0] CMP_OFS_MB_IRQ_MASK    = 16'hF614;
  localparam logic [15:0] CMP_OFS_IRQ_MASK_1     = 16'hF616;
  localparam logic [15:0] CMP_OFS_IRQ_MASK_0     = 16'hF617;
  localparam logic [15:0] CMP_OFS_RX_ERR_CNT     = 16'hF618;
  localparam logic [15:0] CMP_OFS_TX_ERR_CNT     = 16'hF619;
  localparam logic [15:0] CMP_OFS_TEST_CONTROL   = 16'hF61A;
  localparam logic [15:0] CMP_OFS_UNREAD         = 16'hF61B;
  localparam logic [15:0] CMP_OFS_MSG_CTRL_0_0   = 16'hF620;

  localparam int          CMP_ACCESS_STATES = 4;
  localparam logic [3:0]  CMP_TX_MB_MASK    = 4'hE;
  localparam logic [3:0]  CMP_ALL_MB_MASK   = 4'hF;
  localparam int          CMP_EMPTY_BIT     = 0;
  localparam logic [7:0]  CMP_RST_BYTE      = 8'h00;
  localparam logic [3:0]  CMP_RST_NIBBLE    = 4'h0;
  localparam logic [15:0] CMP_RST_ADDR      = 16'h0000;

  typedef enum logic {
    CMP_BUS_IDLE,
    CMP_BUS_BUSY
  } cmp_bus_state_t;

endpackage

// ---- cmp_top.sv ----
// Purpose: Mailbox transmit-pending control, cancel and acknowledge flags,
//          unread-message status and their CPU register access.
// Assumes: All inputs are synchronous to CLK_SYS; event inputs are one-cycle pulses.
// Notes:   Registers of the controller map not held here read as zero.
`timescale 1ns/1ps
`default_nettype none

module cmp_top
  import cmp_pkg::*;
#(
  parameter int ACC_STATES = CMP_ACCESS_STATES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [15:0] CPU_ADDR,
  input  wire logic [7:0]  CPU_WDATA,
  input  wire logic        CPU_RD,
  input  wire logic        CPU_WR,
  output logic      [7:0]  CPU_RDATA,
  output logic             CPU_ACK,
  input  wire logic [3:0]  TX_OK,
  input  wire logic [3:0]  TX_FAIL,
  input  wire logic [3:0]  TX_BUSY,
  input  wire logic [3:0]  RETX_DISABLE,
  input  wire logic [3:0]  RX_NEW,
  input  wire logic [3:0]  RX_REMOTE,
  output logic      [3:0]  TX_REQ,
  output logic      [3:0]  TX_CANCEL,
  output logic             EMPTY_MAILBOX_FLAG
);

  localparam int CW = 3;
  localparam logic [CW-1:0] LAST_CNT = CW'(ACC_STATES - 1);

  if (ACC_STATES < 2 || ACC_STATES > 8) begin : g_bad_states
    $error("ACC_STATES must lie between 2 and 8.");
  end

  // Bus access state.
  cmp_bus_state_t  state_reg;
  cmp_bus_state_t  state_next;
  logic [CW-1:0]   cnt_reg;
  logic [CW-1:0]   cnt_next;
  logic [15:0]     addr_reg;
  logic [15:0]     addr_next;
  logic [7:0]      wdata_reg;
  logic [7:0]      wdata_next;
  logic            is_wr_reg;
  logic            is_wr_next;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic            ack_reg;
  logic            ack_next;
  logic            fire;
  logic            wr_fire;
  logic [3:0]      wnib;

  // Mailbox transmit state.
  logic [7:0]      dir_reg;
  logic [7:0]      dir_next;
  logic [3:0]      pend_reg;
  logic [3:0]      pend_next;
  logic [3:0]      transmit_cancel_request_reg;
  logic [3:0]      transmit_cancel_request_next;
  logic [3:0]      transmit_acknowledge_reg;
  logic [3:0]      transmit_acknowledge_next;
  logic [3:0]      abort_acknowledge_reg;
  logic [3:0]      abort_acknowledge_next;
  logic [3:0]      txreq_reg;
  logic [3:0]      txreq_next;
  logic [7:0]      if1_reg;
  logic [7:0]      if1_next;

  // Receive state.
  logic [3:0]      receive_complete_reg;
  logic [3:0]      receive_complete_next;
  logic [3:0]      remote_frame_request_reg;
  logic [3:0]      remote_frame_request_next;
  logic [3:0]      unread_message_status_reg;
  logic [3:0]      unread_message_status_next;

  // Mailbox event terms.
  logic [3:0]      sw_set;
  logic [3:0]      ok;
  logic [3:0]      fail;
  logic [3:0]      can_idle;
  logic [3:0]      can_fail;
  logic [3:0]      retransmission_disable_fail;
  logic [3:0]      hw_clr;
  logic [3:0]      clr_eff;

  // Bus access sequencer.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    is_wr_next = is_wr_reg;
    ack_next   = 1'b0;
    fire       = 1'b0;
    unique case (state_reg)
      CMP_BUS_IDLE: begin
        if (CPU_RD || CPU_WR) begin
          state_next = CMP_BUS_BUSY;
          cnt_next   = CW'(1);
          addr_next  = CPU_ADDR;
          wdata_next = CPU_WDATA;
          is_wr_next = CPU_WR;
        end
      end
      CMP_BUS_BUSY: begin
        if (cnt_reg == LAST_CNT) begin
          fire       = 1'b1;
          ack_next   = 1'b1;
          state_next = CMP_BUS_IDLE;
          cnt_next   = CW'(0);
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
    endcase
  end

  assign wr_fire = fire && is_wr_reg;
  assign wnib    = wdata_reg[3:0];

  // Read data, latched at the last state of a read.
  always_comb begin
    rdata_next = rdata_reg;
    if (fire && !is_wr_reg) begin
      unique case (addr_reg)
        CMP_OFS_DIRECTION:   rdata_next = dir_reg;
        CMP_OFS_PENDING:     rdata_next = {4'h0, pend_reg & CMP_TX_MB_MASK};
        CMP_OFS_CANCEL:      rdata_next = {4'h0, transmit_cancel_request_reg};
        CMP_OFS_TX_ACK:      rdata_next = {4'h0, transmit_acknowledge_reg};
        CMP_OFS_ABORT_ACK:   rdata_next = {4'h0, abort_acknowledge_reg};
        CMP_OFS_RX_COMPLETE: rdata_next = {4'h0, receive_complete_reg};
        CMP_OFS_REMOTE_REQ:  rdata_next = {4'h0, remote_frame_request_reg};
        CMP_OFS_IRQ_FLAGS_1: rdata_next = if1_reg;
        CMP_OFS_UNREAD:      rdata_next = {4'h0, unread_message_status_reg};
        CMP_OFS_MASTER_CONTROL,
        CMP_OFS_GENERAL_STATUS,
        CMP_OFS_BIT_TIMING_1,
        CMP_OFS_BIT_TIMING_0,
        CMP_OFS_MODULE_CONTROL,
        CMP_OFS_IRQ_FLAGS_0,
        CMP_OFS_MB_IRQ_MASK,
        CMP_OFS_IRQ_MASK_1,
        CMP_OFS_IRQ_MASK_0,
        CMP_OFS_RX_ERR_CNT,
        CMP_OFS_TX_ERR_CNT,
        CMP_OFS_TEST_CONTROL,
        CMP_OFS_MSG_CTRL_0_0: rdata_next = CMP_RST_BYTE;
        default:             rdata_next = CMP_RST_BYTE;
      endcase
    end
  end

  // Mailbox transmit control.
  always_comb begin
    sw_set = CMP_RST_NIBBLE;
    if (wr_fire && addr_reg == CMP_OFS_PENDING) begin
      sw_set = wnib & CMP_TX_MB_MASK & ~dir_reg[3:0];
    end
    ok        = TX_OK & pend_reg & CMP_TX_MB_MASK;
    fail      = TX_FAIL & pend_reg & CMP_TX_MB_MASK & ~ok;
    can_idle  = transmit_cancel_request_reg & pend_reg & ~TX_BUSY & ~ok & ~fail;
    can_fail  = transmit_cancel_request_reg & fail;
    retransmission_disable_fail = RETX_DISABLE & fail & ~transmit_cancel_request_reg;
    hw_clr    = ok | can_idle | can_fail | retransmission_disable_fail;
    pend_next = (pend_reg | sw_set) & ~hw_clr & CMP_TX_MB_MASK;
    clr_eff   = hw_clr & (pend_reg | sw_set);

    transmit_acknowledge_next = transmit_acknowledge_reg | ok;
    abort_acknowledge_next = abort_acknowledge_reg | can_idle | can_fail;
    transmit_cancel_request_next  = transmit_cancel_request_reg & ~clr_eff;
    dir_next   = dir_reg;
    if1_next   = if1_reg;
    if (wr_fire) begin
      unique case (addr_reg)
        CMP_OFS_DIRECTION: begin
          dir_next = wdata_reg;
        end
        CMP_OFS_CANCEL: begin
          transmit_cancel_request_next = wnib & CMP_TX_MB_MASK & ~clr_eff;
        end
        CMP_OFS_TX_ACK: begin
          transmit_acknowledge_next = (transmit_acknowledge_reg & ~wnib) | ok;
        end
        CMP_OFS_ABORT_ACK: begin
          abort_acknowledge_next = (abort_acknowledge_reg & ~wnib) | can_idle | can_fail;
        end
        CMP_OFS_IRQ_FLAGS_1: begin
          if1_next = if1_reg & ~wdata_reg;
        end
        default: begin
        end
      endcase
    end
    transmit_acknowledge_next = transmit_acknowledge_next & CMP_TX_MB_MASK;
    abort_acknowledge_next = abort_acknowledge_next & CMP_TX_MB_MASK;
    if (|clr_eff) begin
      if1_next[CMP_EMPTY_BIT] = 1'b1;
    end
    txreq_next = pend_next & ~dir_next[3:0] & ~transmit_cancel_request_next;
  end

  // Receive flags and unread status.
  always_comb begin
    receive_complete_next = receive_complete_reg;
    remote_frame_request_next = remote_frame_request_reg;
    unread_message_status_next = unread_message_status_reg | (RX_NEW & (receive_complete_reg | remote_frame_request_reg));
    if (wr_fire) begin
      unique case (addr_reg)
        CMP_OFS_RX_COMPLETE: begin
          receive_complete_next = receive_complete_reg & ~wnib;
        end
        CMP_OFS_REMOTE_REQ: begin
          remote_frame_request_next = remote_frame_request_reg & ~wnib;
        end
        CMP_OFS_UNREAD: begin
          unread_message_status_next = (unread_message_status_reg & ~wnib) | (RX_NEW & (receive_complete_reg | remote_frame_request_reg));
        end
        default: begin
        end
      endcase
    end
    receive_complete_next = receive_complete_next | (RX_NEW & ~RX_REMOTE);
    remote_frame_request_next = remote_frame_request_next | (RX_NEW & RX_REMOTE);
  end

  // Bus registers.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg <= CMP_BUS_IDLE;
      cnt_reg   <= CW'(0);
      addr_reg  <= CMP_RST_ADDR;
      wdata_reg <= CMP_RST_BYTE;
      is_wr_reg <= 1'b0;
      rdata_reg <= CMP_RST_BYTE;
      ack_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      is_wr_reg <= is_wr_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  // Mailbox registers.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dir_reg   <= CMP_RST_BYTE;
      pend_reg  <= CMP_RST_NIBBLE;
      transmit_cancel_request_reg  <= CMP_RST_NIBBLE;
      transmit_acknowledge_reg <= CMP_RST_NIBBLE;
      abort_acknowledge_reg <= CMP_RST_NIBBLE;
      txreq_reg <= CMP_RST_NIBBLE;
      if1_reg   <= CMP_RST_BYTE;
      receive_complete_reg  <= CMP_RST_NIBBLE;
      remote_frame_request_reg  <= CMP_RST_NIBBLE;
      unread_message_status_reg  <= CMP_RST_NIBBLE;
    end else begin
      dir_reg   <= dir_next;
      pend_reg  <= pend_next;
      transmit_cancel_request_reg  <= transmit_cancel_request_next;
      transmit_acknowledge_reg <= transmit_acknowledge_next;
      abort_acknowledge_reg <= abort_acknowledge_next;
      txreq_reg <= txreq_next;
      if1_reg   <= if1_next;
      receive_complete_reg  <= receive_complete_next;
      remote_frame_request_reg  <= remote_frame_request_next;
      unread_message_status_reg  <= unread_message_status_next;
    end
  end

  assign CPU_RDATA          = rdata_reg;
  assign CPU_ACK            = ack_reg;
  assign TX_REQ             = txreq_reg;
  assign TX_CANCEL          = transmit_cancel_request_reg;
  assign EMPTY_MAILBOX_FLAG = if1_reg[CMP_EMPTY_BIT];

endmodule

`default_nettype wire

// ---- cmp_checker.sv ----
// Purpose: Port timing and mailbox checks for cmp_top.
// Assumes: ACC_STATES is left at 4.
// Notes:   Attached to cmp_top by bind.
`timescale 1ns/1ps
`default_nettype none
module cmp_checker
  import cmp_pkg::*;
#(
  parameter int ACC_STATES = CMP_ACCESS_STATES
) (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       CPU_RD,
  input wire logic       CPU_WR,
  input wire logic [7:0] CPU_RDATA,
  input wire logic       CPU_ACK,
  input wire logic [3:0] TX_OK,
  input wire logic [3:0] TX_FAIL,
  input wire logic [3:0] RETX_DISABLE,
  input wire logic [3:0] TX_REQ,
  input wire logic [3:0] TX_CANCEL,
  input wire logic       EMPTY_MAILBOX_FLAG
);
  logic [1:0] busy_reg;
  logic [1:0] busy_next;
  logic       taken;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  if (ACC_STATES != 4) begin : g_states_check
    $error("checker timing is written for four access states");
  end
  always_comb begin
    taken = (CPU_RD || CPU_WR) && busy_reg == 2'h0;
    busy_next = taken ? 2'h3 : (busy_reg != 2'h0 ? busy_reg - 2'h1 : 2'h0);
  end
  always_ff @(posedge CLK_SYS) begin
    busy_reg <= RST ? 2'h0 : busy_next;
  end
  sequence s_access_wait;
    !CPU_ACK [*3];
  endsequence
  a_access_four_states: assert property (taken |=> s_access_wait ##1 CPU_ACK)
    else $error("access answer not after four states");
  a_ack_one_cycle: assert property (CPU_ACK |=> !CPU_ACK)
    else $error("acknowledge longer than one cycle");
  a_rdata_holds: assert property (!CPU_ACK |-> $stable(CPU_RDATA))
    else $error("read data moved outside an answer");
  a_bit0_zero: assert property (!TX_REQ[0] && !TX_CANCEL[0])
    else $error("receive-only mailbox shows transmit state");
  a_ok_clears_req: assert property ((TX_OK & TX_REQ) != 4'h0 |=> (TX_REQ & $past(TX_OK)) == 4'h0)
    else $error("sent mailbox still requested");
  a_clear_sets_empty: assert property ((TX_OK & TX_REQ) != 4'h0 |-> ##[1:2] EMPTY_MAILBOX_FLAG)
    else $error("empty flag not set after pending cleared");
  a_noretry_clears: assert property ((TX_FAIL & TX_REQ & RETX_DISABLE) != 4'h0
    |=> (TX_REQ & $past(TX_FAIL & RETX_DISABLE)) == 4'h0)
    else $error("failed mailbox retried with retransmission disabled");
  a_retry_keeps: assert property ((TX_FAIL & TX_REQ & ~RETX_DISABLE) != 4'h0 && busy_reg != 2'h1
    |=> (TX_REQ & $past(TX_FAIL & ~RETX_DISABLE)) == $past(TX_FAIL & TX_REQ & ~RETX_DISABLE))
    else $error("failed mailbox dropped instead of retried");
endmodule
bind cmp_top cmp_checker #(.ACC_STATES(ACC_STATES)) cmp_checker_inst (.CLK_SYS(CLK_SYS), .RST(RST),
  .CPU_RD(CPU_RD), .CPU_WR(CPU_WR), .CPU_RDATA(CPU_RDATA), .CPU_ACK(CPU_ACK), .TX_OK(TX_OK),
  .TX_FAIL(TX_FAIL), .RETX_DISABLE(RETX_DISABLE), .TX_REQ(TX_REQ), .TX_CANCEL(TX_CANCEL),
  .EMPTY_MAILBOX_FLAG(EMPTY_MAILBOX_FLAG));
`default_nettype wire

// ---- cmp_can_node.sv ----
// Purpose: Behavioural CAN node answering transmit requests.
// Assumes: Each attempt lasts four cycles; ok or fail comes three cycles after it starts.
// Notes:   hold keeps new attempts from starting; a started attempt runs to its end.
//          fail_mode makes a mailbox's attempts fail.
`timescale 1ns/1ps
`default_nettype none
module cmp_can_node (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] req,
  input  wire logic [3:0] fail_mode,
  input  wire logic       hold,
  output logic      [3:0] ok,
  output logic      [3:0] fail,
  output logic      [3:0] busy
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [3:0] cur_reg;
  logic [3:0] cur_next;
  always_comb begin
    busy = (cnt_reg != 2'h0) ? cur_reg : (hold ? 4'h0 : req);
    cnt_next = (busy != 4'h0) ? cnt_reg + 2'h1 : 2'h0;
    cur_next = busy;
    ok = (cnt_reg == 2'h3) ? busy & ~fail_mode : 4'h0;
    fail = (cnt_reg == 2'h3) ? busy & fail_mode : 4'h0;
  end
  always_ff @(posedge clk) begin
    cnt_reg <= rst ? 2'h0 : cnt_next;
    cur_reg <= rst ? 4'h0 : cur_next;
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for cmp_top.
// Assumes: The CAN node model answers the transmit requests.
// Notes:   Registers are reached through the four-state access task.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cmp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = CMP_RST_ADDR;
  logic [7:0]  wdata = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  rdata;
  logic        ack;
  logic [3:0]  ok, fail, busy, req, cancel;
  logic        empty;
  logic [3:0]  retx = 4'h0;
  logic [3:0]  rx_new = 4'h0;
  logic [3:0]  rx_rem = 4'h0;
  logic [3:0]  fmode = 4'h0;
  logic        hold = 1'b1;
  logic [7:0]  q;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  cmp_top cmp_top_inst (.CLK_SYS(clk), .RST(rst), .CPU_ADDR(addr), .CPU_WDATA(wdata), .CPU_RD(rd),
    .CPU_WR(wr), .CPU_RDATA(rdata), .CPU_ACK(ack), .TX_OK(ok), .TX_FAIL(fail), .TX_BUSY(busy),
    .RETX_DISABLE(retx), .RX_NEW(rx_new), .RX_REMOTE(rx_rem), .TX_REQ(req), .TX_CANCEL(cancel),
    .EMPTY_MAILBOX_FLAG(empty));
  cmp_can_node cmp_can_node_inst (.clk(clk), .rst(rst), .req(req), .fail_mode(fmode), .hold(hold),
    .ok(ok), .fail(fail), .busy(busy));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    while (ack !== 1'b1 && n < 9) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 9) chk("access answer", 8'h01, 8'h00);
    q = rdata;
  endtask
  task automatic rdc(input string n, input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(n, e, q);
  endtask
  task automatic rx(input logic [3:0] m, input logic [3:0] r);
    @(posedge clk);
    rx_new <= m;
    rx_rem <= r;
    @(posedge clk);
    rx_new <= 4'h0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc("pending", CMP_OFS_PENDING, 8'h00);
    rdc("unread", CMP_OFS_UNREAD, 8'h00);
    rdc("not held", CMP_OFS_MASTER_CONTROL, 8'h00);
    $display("test reset done");
    acc(1'b1, CMP_OFS_PENDING, 8'hFF);
    acc(1'b1, CMP_OFS_PENDING, 8'h00);
    rdc("pending", CMP_OFS_PENDING, 8'h0E);
    @(posedge clk) hold <= 1'b0;
    repeat (12) @(posedge clk);
    rdc("pending", CMP_OFS_PENDING, 8'h00);
    rdc("tx ack", CMP_OFS_TX_ACK, 8'h0E);
    rdc("flags 1", CMP_OFS_IRQ_FLAGS_1, 8'h01);
    acc(1'b1, CMP_OFS_IRQ_FLAGS_1, 8'h01);
    rdc("flags 1", CMP_OFS_IRQ_FLAGS_1, 8'h00);
    $display("test send done");
    @(posedge clk) hold <= 1'b1;
    acc(1'b1, CMP_OFS_DIRECTION, 8'h04);
    acc(1'b1, CMP_OFS_PENDING, 8'h06);
    acc(1'b1, CMP_OFS_DIRECTION, 8'h06);
    @(posedge clk) hold <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("tx req", 8'h00, {4'h0, req});
    rdc("pending", CMP_OFS_PENDING, 8'h02);
    acc(1'b1, CMP_OFS_CANCEL, 8'h02);
    rdc("pending", CMP_OFS_PENDING, 8'h00);
    rdc("abort ack", CMP_OFS_ABORT_ACK, 8'h02);
    chk("cancel out", 8'h00, {4'h0, cancel});
    chk("empty", 8'h01, {7'h00, empty});
    acc(1'b1, CMP_OFS_DIRECTION, 8'h00);
    $display("test direction done");
    @(posedge clk) fmode <= 4'h8;
    acc(1'b1, CMP_OFS_PENDING, 8'h08);
    repeat (20) @(posedge clk);
    rdc("pending", CMP_OFS_PENDING, 8'h08);
    @(posedge clk) retx <= 4'h8;
    repeat (10) @(posedge clk);
    rdc("pending", CMP_OFS_PENDING, 8'h00);
    $display("test retry done");
    @(posedge clk) retx <= 4'h0;
    acc(1'b1, CMP_OFS_PENDING, 8'h08);
    acc(1'b1, CMP_OFS_CANCEL, 8'h08);
    @(posedge clk);
    #1;
    chk("cancel out", 8'h08, {4'h0, cancel});
    rdc("pending", CMP_OFS_PENDING, 8'h00);
    rdc("abort ack", CMP_OFS_ABORT_ACK, 8'h0A);
    $display("test cancel in flight done");
    rx(4'h5, 4'h1);
    rx(4'h5, 4'h1);
    rdc("rx complete", CMP_OFS_RX_COMPLETE, 8'h04);
    rdc("remote", CMP_OFS_REMOTE_REQ, 8'h01);
    rdc("unread", CMP_OFS_UNREAD, 8'h05);
    acc(1'b1, CMP_OFS_UNREAD, 8'h00);
    rdc("unread", CMP_OFS_UNREAD, 8'h05);
    acc(1'b1, CMP_OFS_UNREAD, 8'hFF);
    rdc("unread", CMP_OFS_UNREAD, 8'h00);
    $display("test unread done");
    complete_run();
  end
endmodule
`default_nettype wire
